// ==== hdl/amp_diag_pkg.sv ====
// constants, field positions and state types of the amplifier report bank
// Operation
// - impedance read-only byte, 0.2496 ohm per step
// - phase result split upper/lower byte
// - settling result split upper/lower byte
// - writing one to fault-clear clears faults
// - source-flip bit swaps bridged signal source
// - over-temperature shutdown latched or self-restarting
// - clip detection enabled, on after reset
// - latch-select zero latches warning pin
// - both channels routed to warning pin
// - clip after window count of full cycles
// - per-channel sticky clip status bits
// - per-channel sticky current-limit warning bits
// - impedance scaling taken from diag controls
// - per-channel diag only while enabled
// - clip mask hides clipping from pin
package amp_diag_pkg;
  localparam logic [7:0] ADDR_PIN_CTRL = 8'h14;
  localparam logic [7:0] ADDR_DIAG_CTRL1 = 8'h15;
  localparam logic [7:0] ADDR_DIAG_CTRL2 = 8'h16;
  localparam logic [7:0] ADDR_CH1_IMP = 8'h17;
  localparam logic [7:0] ADDR_CH2_IMP = 8'h18;
  localparam logic [7:0] ADDR_ANGLE_UP = 8'h1b;
  localparam logic [7:0] ADDR_ANGLE_LO = 8'h1c;
  localparam logic [7:0] ADDR_SETTLE_UP = 8'h1d;
  localparam logic [7:0] ADDR_SETTLE_LO = 8'h1e;
  localparam logic [7:0] ADDR_FAULT_BRIDGE = 8'h21;
  localparam logic [7:0] ADDR_CLIP_CTRL = 8'h22;
  localparam logic [7:0] ADDR_CLIP_WIN = 8'h23;
  localparam logic [7:0] ADDR_CLIP_STAT = 8'h24;
  localparam logic [7:0] ADDR_CAP_STAT = 8'h25;
  localparam logic [7:0] ADDR_MISC4 = 8'h26;

  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_CLIP_CTRL = 8'h01;
  localparam logic [7:0] RST_CLIP_WIN = 8'h14;
  localparam logic [7:0] RST_MISC4 = 8'h40;

  // writable bits; the rest read back as zero
  localparam logic [7:0] WMASK_FAULT_BRIDGE = 8'hf8;
  localparam logic [7:0] WMASK_CLIP_CTRL = 8'h07;

  localparam int BIT_FAULT_CLEAR = 7;
  localparam int BIT_SOURCE_FLIP = 6;
  localparam int BIT_CAP_HIDE = 5;
  localparam int BIT_SELF_RESTART = 3;
  localparam int BIT_DETECT_ON = 0;
  localparam int BIT_CLIP_LATCH = 1;
  localparam int BIT_CLIP_PIN = 2;
  localparam int BIT_MASK_CLIP = 1;
  localparam int BIT_CH1_GAIN = 7;
  localparam int BIT_CH2_GAIN = 6;
  localparam int BIT_CH1_DIAG_ON = 3;
  localparam int BIT_CH2_DIAG_ON = 2;
  localparam int BIT_LOOPBACK = 7;
  localparam int BIT_TIMING = 4;
  localparam int BIT_CURRENT_LO = 2;
  localparam int BIT_CURRENT_HI = 3;

  typedef enum logic [1:0] {
    OT_RUN = 2'b00,
    OT_SHUT = 2'b01,
    OT_HOLD = 2'b11
  } overheat_e;

  typedef struct packed {
    logic [7:0] impedance1;
    logic [7:0] impedance2;
    logic [15:0] angle;
    logic [15:0] settle;
  } diag_result_s;

  typedef struct packed {
    logic [7:0] count;
    logic detected;
  } clip_state_s;

  typedef struct packed {
    logic [7:0] pinCtrl;
    logic [7:0] diagCtrl1;
    logic [7:0] diagCtrl2;
    logic [7:0] faultBridge;
    logic [7:0] clipCtrl;
    logic [7:0] clipWindow;
    logic [7:0] misc4;
    logic [1:0] clipFlag;
    logic [1:0] capFlag;
    diag_result_s result;
    overheat_e heat;
    logic heatShutdown;
    logic [7:0] rdData;
    logic rdValid;
    logic warn_b;
    logic clearPulse;
    logic sourceFlip;
  } state_s;
endpackage : amp_diag_pkg

// ==== hdl/clip_window_detect.sv ====
// one channel of clip detection: counts consecutive full-duty pwm cycles
`timescale 1ns/100ps
`default_nettype none
module clip_window_detect #(
  parameter int WIDTH = 8
) (
  input wire logic clk_sys,
  input wire logic rstSyncB,
  input wire logic ce,
  input wire logic enable,
  input wire logic [WIDTH-1:0] window,
  input wire logic tick,
  input wire logic fullDuty,
  output logic detected
);
  amp_diag_pkg::clip_state_s s;
  amp_diag_pkg::clip_state_s sNext;
  logic [WIDTH-1:0] cntInc;

  always_comb begin
    sNext = s;
    cntInc = (s.count == {WIDTH{1'b1}}) ? s.count : s.count + 8'h01;
    if (!enable) begin
      sNext.count = 8'h00;
      sNext.detected = 1'b0;
    end else if (tick) begin
      if (fullDuty) begin
        sNext.count = cntInc;
        sNext.detected = (cntInc >= window);
      end else begin
        sNext.count = 8'h00;
        sNext.detected = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstSyncB) begin
    if (!rstSyncB) begin
      s <= '0;
    end else if (ce) begin
      s <= sNext;
    end
  end

  assign detected = s.detected;

  short_run_a: assert property (
    @(posedge clk_sys) disable iff (!rstSyncB)
    ce && enable && tick && fullDuty && (cntInc < window) |=> !detected)
    else $error("clip reported before window count");
  off_clears_a: assert property (
    @(posedge clk_sys) disable iff (!rstSyncB)
    ce && !enable |=> !detected && s.count == 8'h00)
    else $error("clip detect active while disabled");
endmodule : clip_window_detect
`default_nettype wire

// ==== hdl/amp_diag_report_and_clip_regs.sv ====
// report, fault/bridge control and clip register bank of the amplifier
`timescale 1ns/100ps
`default_nettype none
module amp_diag_report_and_clip_regs #(
  parameter int CHANNELS = 2
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  output logic regRdValid,
  input wire amp_diag_pkg::diag_result_s diagResult,
  input wire logic diagResultValid,
  input wire logic pwmCycleTick,
  input wire logic [1:0] pwmFullDuty,
  input wire logic [1:0] currentLimitRaw,
  input wire logic overheatRaw,
  input wire logic parallelBridgeMode,
  output logic [1:0] acDiagOn,
  output logic [1:0] acDiagGain,
  output logic acDiagLoopback,
  output logic acDiagTiming,
  output logic [1:0] acDiagCurrent,
  output logic parallelBridgeSourceFlip,
  output logic overheatShutdown,
  output logic faultClear,
  output logic warn_b
);
  logic [1:0] rstSync;
  logic rstSyncB;
  logic [2:0] pinMeta;
  logic [2:0] pinSync;
  logic [1:0] capSync;
  logic heatSync;
  logic [1:0] clipDetected;
  logic clearNow;
  logic [1:0] clipSel;
  amp_diag_pkg::state_s s;
  amp_diag_pkg::state_s sNext;

  // reset leaves asynchronously-asserted, synchronously-released
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rstSync <= 2'h0;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  assign rstSyncB = rstSync[1];

  // analog comparator flags arrive unsynchronised
  always_ff @(posedge clk_sys or negedge rstSyncB) begin
    if (!rstSyncB) begin
      pinMeta <= 3'h0;
      pinSync <= 3'h0;
    end else if (ce) begin
      pinMeta <= {overheatRaw, currentLimitRaw};
      pinSync <= pinMeta;
    end
  end
  assign capSync = pinSync[1:0];
  assign heatSync = pinSync[2];

  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : g_clip
      clip_window_detect #(.WIDTH(8)) u_detect (
        .clk_sys(clk_sys),
        .rstSyncB(rstSyncB),
        .ce(ce),
        .enable(s.clipCtrl[amp_diag_pkg::BIT_DETECT_ON]),
        .window(s.clipWindow),
        .tick(pwmCycleTick),
        .fullDuty(pwmFullDuty[ch]),
        .detected(clipDetected[ch])
      );
    end
  endgenerate

  assign clearNow = regWrEn && (regAddr == amp_diag_pkg::ADDR_FAULT_BRIDGE)
    && regWrData[amp_diag_pkg::BIT_FAULT_CLEAR];

  always_comb begin
    sNext = s;
    clipSel = 2'h0;
    sNext.clearPulse = clearNow;
    // read-only addresses have no write path
    if (regWrEn) begin
      case (regAddr)
        amp_diag_pkg::ADDR_PIN_CTRL: sNext.pinCtrl = regWrData;
        amp_diag_pkg::ADDR_DIAG_CTRL1: sNext.diagCtrl1 = regWrData;
        amp_diag_pkg::ADDR_DIAG_CTRL2: sNext.diagCtrl2 = regWrData;
        amp_diag_pkg::ADDR_FAULT_BRIDGE: begin
          sNext.faultBridge = regWrData & amp_diag_pkg::WMASK_FAULT_BRIDGE;
        end
        amp_diag_pkg::ADDR_CLIP_CTRL: begin
          sNext.clipCtrl = regWrData & amp_diag_pkg::WMASK_CLIP_CTRL;
        end
        amp_diag_pkg::ADDR_CLIP_WIN: sNext.clipWindow = regWrData;
        amp_diag_pkg::ADDR_MISC4: sNext.misc4 = regWrData;
        default: sNext.misc4 = s.misc4;
      endcase
    end
    if (diagResultValid) begin
      if (s.diagCtrl1[amp_diag_pkg::BIT_CH1_DIAG_ON]) begin
        sNext.result.impedance1 = diagResult.impedance1;
      end
      if (s.diagCtrl1[amp_diag_pkg::BIT_CH2_DIAG_ON]) begin
        sNext.result.impedance2 = diagResult.impedance2;
      end
      if (s.diagCtrl1[amp_diag_pkg::BIT_CH1_DIAG_ON]
          || s.diagCtrl1[amp_diag_pkg::BIT_CH2_DIAG_ON]) begin
        sNext.result.angle = diagResult.angle;
        sNext.result.settle = diagResult.settle;
      end
    end
    // sticky clip flags, set beats clear
    sNext.clipFlag = (s.clipFlag & ~{2{clearNow}}) | clipDetected;
    // sticky current-limit flags, set beats clear
    sNext.capFlag = (s.capFlag & ~{2{clearNow}}) | capSync;
    case (s.heat)
      amp_diag_pkg::OT_RUN: begin
        if (heatSync) begin
          sNext.heat = amp_diag_pkg::OT_SHUT;
        end
      end
      amp_diag_pkg::OT_SHUT: begin
        if (!heatSync) begin
          sNext.heat = s.faultBridge[amp_diag_pkg::BIT_SELF_RESTART] ?
            amp_diag_pkg::OT_RUN : amp_diag_pkg::OT_HOLD;
        end
      end
      amp_diag_pkg::OT_HOLD: begin
        if (heatSync) begin
          sNext.heat = amp_diag_pkg::OT_SHUT;
        end else if (clearNow
            || s.faultBridge[amp_diag_pkg::BIT_SELF_RESTART]) begin
          sNext.heat = amp_diag_pkg::OT_RUN;
        end
      end
      default: sNext.heat = amp_diag_pkg::OT_RUN;
    endcase
    sNext.heatShutdown = (sNext.heat != amp_diag_pkg::OT_RUN);
    sNext.sourceFlip = parallelBridgeMode
      && sNext.faultBridge[amp_diag_pkg::BIT_SOURCE_FLIP];
    clipSel = s.clipCtrl[amp_diag_pkg::BIT_CLIP_LATCH] ?
      clipDetected : sNext.clipFlag;
    // both channels onto the warning pin
    sNext.warn_b = !(((|clipSel) && !s.pinCtrl[amp_diag_pkg::BIT_MASK_CLIP])
      || ((|sNext.capFlag)
      && !s.faultBridge[amp_diag_pkg::BIT_CAP_HIDE]));
    sNext.rdValid = regRdEn;
    if (regRdEn) begin
      case (regAddr)
        amp_diag_pkg::ADDR_PIN_CTRL: sNext.rdData = s.pinCtrl;
        amp_diag_pkg::ADDR_DIAG_CTRL1: sNext.rdData = s.diagCtrl1;
        amp_diag_pkg::ADDR_DIAG_CTRL2: sNext.rdData = s.diagCtrl2;
        amp_diag_pkg::ADDR_CH1_IMP: sNext.rdData = s.result.impedance1;
        amp_diag_pkg::ADDR_CH2_IMP: sNext.rdData = s.result.impedance2;
        amp_diag_pkg::ADDR_ANGLE_UP: sNext.rdData = s.result.angle[15:8];
        amp_diag_pkg::ADDR_ANGLE_LO: sNext.rdData = s.result.angle[7:0];
        amp_diag_pkg::ADDR_SETTLE_UP: sNext.rdData = s.result.settle[15:8];
        amp_diag_pkg::ADDR_SETTLE_LO: sNext.rdData = s.result.settle[7:0];
        amp_diag_pkg::ADDR_FAULT_BRIDGE: sNext.rdData = s.faultBridge;
        amp_diag_pkg::ADDR_CLIP_CTRL: sNext.rdData = s.clipCtrl;
        amp_diag_pkg::ADDR_CLIP_WIN: sNext.rdData = s.clipWindow;
        amp_diag_pkg::ADDR_CLIP_STAT: sNext.rdData = {6'h00, s.clipFlag};
        amp_diag_pkg::ADDR_CAP_STAT: sNext.rdData = {6'h00, s.capFlag};
        amp_diag_pkg::ADDR_MISC4: sNext.rdData = s.misc4;
        default: sNext.rdData = amp_diag_pkg::RST_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstSyncB) begin
    if (!rstSyncB) begin
      s <= '0;
      s.clipCtrl <= amp_diag_pkg::RST_CLIP_CTRL;
      s.clipWindow <= amp_diag_pkg::RST_CLIP_WIN;
      s.misc4 <= amp_diag_pkg::RST_MISC4;
      s.heat <= amp_diag_pkg::OT_RUN;
      s.warn_b <= 1'b1;
    end else if (ce) begin
      s <= sNext;
    end
  end

  assign regRdData = s.rdData;
  assign regRdValid = s.rdValid;
  // per-channel enables out to the engine
  assign acDiagOn = {s.diagCtrl1[amp_diag_pkg::BIT_CH2_DIAG_ON],
    s.diagCtrl1[amp_diag_pkg::BIT_CH1_DIAG_ON]};
  // scaling controls out to the engine
  assign acDiagGain = {s.diagCtrl1[amp_diag_pkg::BIT_CH2_GAIN],
    s.diagCtrl1[amp_diag_pkg::BIT_CH1_GAIN]};
  assign acDiagLoopback = s.diagCtrl2[amp_diag_pkg::BIT_LOOPBACK];
  assign acDiagTiming = s.diagCtrl2[amp_diag_pkg::BIT_TIMING];
  assign acDiagCurrent = s.diagCtrl2[amp_diag_pkg::BIT_CURRENT_HI:
    amp_diag_pkg::BIT_CURRENT_LO];
  assign parallelBridgeSourceFlip = s.sourceFlip;
  assign overheatShutdown = s.heatShutdown;
  assign faultClear = s.clearPulse;
  assign warn_b = s.warn_b;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstSyncB);

  imp_capture_a: assert property (
    ce && diagResultValid && acDiagOn[0]
    |=> s.result.impedance1 == $past(diagResult.impedance1))
    else $error("impedance not captured");
  // a capture in the read cycle updates the byte after the old value is sent
  angle_upper_a: assert property (
    ce && regRdEn && regAddr == amp_diag_pkg::ADDR_ANGLE_UP && !diagResultValid
    |=> regRdValid && regRdData == s.result.angle[15:8])
    else $error("phase upper byte wrong");
  settle_lower_a: assert property (
    ce && regRdEn && regAddr == amp_diag_pkg::ADDR_SETTLE_LO
    && !diagResultValid
    |=> regRdValid && regRdData == s.result.settle[7:0])
    else $error("settling lower byte wrong");
  clear_flags_a: assert property (
    ce && clearNow && clipDetected == 2'h0 && capSync == 2'h0
    |=> s.clipFlag == 2'h0 && s.capFlag == 2'h0 && faultClear)
    else $error("fault clear left status set");
  clear_heat_a: assert property (
    ce && clearNow && s.heat == amp_diag_pkg::OT_HOLD && !heatSync
    |=> !overheatShutdown)
    else $error("fault clear did not release shutdown");
  flip_source_a: assert property (
    ce && !parallelBridgeMode |=> !parallelBridgeSourceFlip)
    else $error("source flipped outside bridged mode");
  flip_bridged_a: assert property (
    ce && parallelBridgeMode && !regWrEn
    && s.faultBridge[amp_diag_pkg::BIT_SOURCE_FLIP]
    |=> parallelBridgeSourceFlip)
    else $error("bridged source not flipped");
  heat_enter_a: assert property (
    ce && heatSync |=> overheatShutdown)
    else $error("overheat did not shut down");
  heat_latched_a: assert property (
    ce && s.heat == amp_diag_pkg::OT_HOLD && !heatSync && !clearNow
    && !s.faultBridge[amp_diag_pkg::BIT_SELF_RESTART]
    |=> overheatShutdown)
    else $error("latched shutdown released early");
  heat_restart_a: assert property (
    ce && s.heat == amp_diag_pkg::OT_SHUT && !heatSync
    && s.faultBridge[amp_diag_pkg::BIT_SELF_RESTART]
    |=> !overheatShutdown)
    else $error("self restart did not happen");
  warn_latched_a: assert property (
    ce && !regWrEn && !s.clipCtrl[amp_diag_pkg::BIT_CLIP_LATCH]
    && (|s.clipFlag) && !s.pinCtrl[amp_diag_pkg::BIT_MASK_CLIP]
    |=> !warn_b)
    else $error("latched clip warning dropped");
  warn_route_a: assert property (
    ce && !regWrEn && s.clipCtrl[amp_diag_pkg::BIT_CLIP_LATCH]
    && clipDetected[1] && !s.pinCtrl[amp_diag_pkg::BIT_MASK_CLIP]
    |=> !warn_b)
    else $error("channel two clip not on warning pin");
  clip_mask_a: assert property (
    ce && !regWrEn && s.pinCtrl[amp_diag_pkg::BIT_MASK_CLIP]
    && s.faultBridge[amp_diag_pkg::BIT_CAP_HIDE] |=> warn_b)
    else $error("masked warning reached pin");
  clip_flag_a: assert property (
    ce && clipDetected[0] |=> s.clipFlag[0] ##1 (!ce || s.clipFlag[0]
    || $past(clearNow)))
    else $error("clip flag not set");
  status_upper_a: assert property (
    ce && regRdEn && regAddr == amp_diag_pkg::ADDR_CLIP_STAT
    |=> regRdData[7:2] == 6'h00)
    else $error("clip status reserved bits set");
  cap_flag_a: assert property (
    ce && capSync[1] |=> s.capFlag[1])
    else $error("current limit flag not set");
  scale_ctrl_a: assert property (
    ce && regWrEn && regAddr == amp_diag_pkg::ADDR_DIAG_CTRL2
    |=> acDiagCurrent == $past(regWrData[3:2]))
    else $error("diag current setting not applied");
  diag_enable_a: assert property (
    ce && regWrEn && regAddr == amp_diag_pkg::ADDR_DIAG_CTRL1
    |=> acDiagOn[0] == $past(regWrData[3]))
    else $error("diag enable not applied");
  diag_off_keep_a: assert property (
    ce && diagResultValid && !acDiagOn[1]
    |=> $stable(s.result.impedance2))
    else $error("disabled channel result changed");
  ro_write_a: assert property (
    ce && regWrEn && regAddr == amp_diag_pkg::ADDR_CH1_IMP
    && !diagResultValid |=> $stable(s.result.impedance1))
    else $error("read-only byte changed by write");
  ctrl_reserved_a: assert property (
    ce && regWrEn && regAddr == amp_diag_pkg::ADDR_CLIP_CTRL
    |=> s.clipCtrl[7:3] == 5'h00)
    else $error("reserved clip control bits written");
  detect_reset_a: assert property (
    $rose(rstSyncB) |-> s.clipCtrl == amp_diag_pkg::RST_CLIP_CTRL)
    else $error("clip detect not enabled after reset");
endmodule : amp_diag_report_and_clip_regs
`default_nettype wire

// ==== tb/host_port_model.sv ====
// host-side model driving the register byte port of the bank
`timescale 1ns/100ps
`default_nettype none
module host_port_model (
  input wire logic clk_sys,
  output logic [7:0] regAddr,
  output logic [7:0] regWrData,
  output logic regWrEn,
  output logic regRdEn,
  input wire logic [7:0] regRdData,
  input wire logic regRdValid
);
  initial begin
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
  end

  // idle bus shows inverted values so a stale address never looks valid
  task automatic release_bus();
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regAddr = ~regAddr;
    regWrData = ~regWrData;
  endtask : release_bus

  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(negedge clk_sys);
    regAddr = addr;
    regWrData = (addr == amp_diag_pkg::ADDR_CLIP_CTRL) ?
      (data & ~(8'h01 << amp_diag_pkg::BIT_CLIP_PIN)) : data;
    regWrEn = 1'b1;
    @(negedge clk_sys);
    release_bus();
  endtask : write_reg

  // returns in the cycle where the answer stands
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data,
                          output logic ok);
    @(negedge clk_sys);
    regAddr = addr;
    regRdEn = 1'b1;
    // valid stands only until the next rising edge
    @(negedge clk_sys);
    ok = regRdValid;
    data = regRdData;
    release_bus();
  endtask : read_reg
endmodule : host_port_model
`default_nettype wire

// ==== tb/tb.sv ====
// self-checking bench of the amplifier report and clip register bank
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clk_sys, rst_b, ce, regWrEn, regRdEn, regRdValid;
  logic [7:0] regAddr, regWrData, regRdData;
  logic diagResultValid, pwmCycleTick, overheatRaw, parallelBridgeMode;
  amp_diag_pkg::diag_result_s diagResult;
  logic [1:0] pwmFullDuty, currentLimitRaw, acDiagOn, acDiagGain;
  logic [1:0] acDiagCurrent;
  logic acDiagLoopback, acDiagTiming, parallelBridgeSourceFlip;
  logic overheatShutdown, faultClear, warn_b;
  int errors = 0;
  int checksDone = 0;
  int cycles = 0;
  localparam logic [7:0] RADDR [16] = '{8'h14, 8'h15, 8'h16, 8'h17, 8'h18,
    8'h1b, 8'h1c, 8'h1d, 8'h1e, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26,
    8'h30};

  amp_diag_report_and_clip_regs #(.CHANNELS(2)) DUT (
    .clk_sys(clk_sys), .rst_b(rst_b), .ce(ce),
    .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid),
    .diagResult(diagResult), .diagResultValid(diagResultValid),
    .pwmCycleTick(pwmCycleTick), .pwmFullDuty(pwmFullDuty),
    .currentLimitRaw(currentLimitRaw), .overheatRaw(overheatRaw),
    .parallelBridgeMode(parallelBridgeMode), .acDiagOn(acDiagOn),
    .acDiagGain(acDiagGain), .acDiagLoopback(acDiagLoopback),
    .acDiagTiming(acDiagTiming), .acDiagCurrent(acDiagCurrent),
    .parallelBridgeSourceFlip(parallelBridgeSourceFlip),
    .overheatShutdown(overheatShutdown), .faultClear(faultClear),
    .warn_b(warn_b)
  );

  host_port_model HOST (
    .clk_sys(clk_sys), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .regRdValid(regRdValid)
  );

  task automatic end_sim();
    $display("checks %0d errors %0d", checksDone, errors);
    if (errors == 0 && checksDone > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim

  task automatic wait_cycles(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : wait_cycles

  task automatic check_reg(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] got;
    logic ok;
    HOST.read_reg(addr, got, ok);
    checksDone++;
    if (ok !== 1'b1 || got !== exp) begin
      errors++;
      $display("wrong value at %0t: reg %h gave %h", $time, addr, got);
    end
  endtask : check_reg

  task automatic check_pin(input logic [1:0] got, input logic [1:0] exp);
    checksDone++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: pin %b want %b", $time, got, exp);
    end
  endtask : check_pin

  task automatic ticks(input int n, input logic [1:0] full);
    repeat (n) begin
      @(negedge clk_sys);
      pwmFullDuty = full;
      pwmCycleTick = 1'b1;
      @(negedge clk_sys);
      pwmCycleTick = 1'b0;
    end
    wait_cycles(3);
  endtask : ticks

  task automatic capture(input amp_diag_pkg::diag_result_s r);
    @(negedge clk_sys);
    diagResult = r;
    diagResultValid = 1'b1;
    @(negedge clk_sys);
    diagResultValid = 1'b0;
    diagResult = ~r;
  endtask : capture

  task automatic reset_values();
    logic [7:0] e;
    foreach (RADDR[i]) begin
      e = (RADDR[i] == 8'h22) ? 8'h01 : (RADDR[i] == 8'h23) ? 8'h14 :
          (RADDR[i] == 8'h26) ? 8'h40 : 8'h00;
      check_reg(RADDR[i], e);
    end
  endtask : reset_values

  task automatic read_only_bytes();
    foreach (RADDR[i]) begin
      if (i inside {[3:8], [12:13], 15}) begin
        HOST.write_reg(RADDR[i], 8'hff);
        check_reg(RADDR[i], 8'h00);
      end
    end
    HOST.write_reg(8'h22, 8'hff);
    check_reg(8'h22, 8'h03);
    HOST.write_reg(8'h21, 8'hff);
    check_reg(8'h21, 8'hf8);
    HOST.write_reg(8'h21, 8'h00);
    // back to latched pin mode for the clip scenarios
    HOST.write_reg(8'h22, 8'h01);
  endtask : read_only_bytes

  task automatic diag_reports();
    HOST.write_reg(8'h15, 8'hcc);
    HOST.write_reg(8'h16, 8'h9c);
    check_pin(acDiagOn, 2'h3);
    check_pin(acDiagGain, 2'h3);
    check_pin({acDiagLoopback, acDiagTiming}, 2'h3);
    check_pin(acDiagCurrent, 2'h3);
    capture({8'h5a, 8'ha5, 16'h1234, 16'hbeef});
    check_reg(8'h17, 8'h5a);
    check_reg(8'h18, 8'ha5);
    check_reg(8'h1b, 8'h12);
    check_reg(8'h1c, 8'h34);
    check_reg(8'h1d, 8'hbe);
    check_reg(8'h1e, 8'hef);
    HOST.write_reg(8'h15, 8'h08);
    capture({8'hff, 8'h22, 16'h3344, 16'h5566});
    check_reg(8'h17, 8'hff);
    check_reg(8'h18, 8'ha5);
    check_reg(8'h1c, 8'h44);
    check_reg(8'h1d, 8'h55);
  endtask : diag_reports

  task automatic clip_latched();
    HOST.write_reg(8'h23, 8'h03);
    check_reg(8'h23, 8'h03);
    ticks(2, 2'h1);
    ticks(1, 2'h0);
    ticks(2, 2'h1);
    check_reg(8'h24, 8'h00);
    ticks(1, 2'h1);
    check_reg(8'h24, 8'h01);
    check_pin(2'(warn_b), 2'h0);
    ticks(1, 2'h0);
    check_pin(2'(warn_b), 2'h0);
    HOST.write_reg(8'h14, 8'h02);
    wait_cycles(2);
    check_pin(2'(warn_b), 2'h1);
    HOST.write_reg(8'h14, 8'h00);
    HOST.write_reg(8'h21, 8'h80);
    check_pin(2'(faultClear), 2'h1);
    wait_cycles(1);
    check_pin(2'(faultClear), 2'h0);
    check_reg(8'h24, 8'h00);
    check_pin(2'(warn_b), 2'h1);
  endtask : clip_latched

  task automatic clip_follow();
    HOST.write_reg(8'h22, 8'h03);
    ticks(3, 2'h2);
    check_reg(8'h24, 8'h02);
    check_pin(2'(warn_b), 2'h0);
    ticks(1, 2'h0);
    check_pin(2'(warn_b), 2'h1);
    check_reg(8'h24, 8'h02);
    HOST.write_reg(8'h22, 8'h02);
    HOST.write_reg(8'h21, 8'h80);
    ticks(4, 2'h3);
    check_reg(8'h24, 8'h00);
    ticks(1, 2'h0);
  endtask : clip_follow

  task automatic cap_flags();
    currentLimitRaw = 2'h2;
    wait_cycles(4);
    currentLimitRaw = 2'h0;
    wait_cycles(4);
    check_reg(8'h25, 8'h02);
    check_pin(2'(warn_b), 2'h0);
    HOST.write_reg(8'h21, 8'h20);
    wait_cycles(2);
    check_pin(2'(warn_b), 2'h1);
    HOST.write_reg(8'h21, 8'h80);
    check_reg(8'h25, 8'h00);
  endtask : cap_flags

  task automatic overheat_and_bridge();
    HOST.write_reg(8'h21, 8'h00);
    overheatRaw = 1'b1;
    wait_cycles(5);
    check_pin(2'(overheatShutdown), 2'h1);
    overheatRaw = 1'b0;
    wait_cycles(5);
    check_pin(2'(overheatShutdown), 2'h1);
    HOST.write_reg(8'h21, 8'h80);
    wait_cycles(3);
    check_pin(2'(overheatShutdown), 2'h0);
    HOST.write_reg(8'h21, 8'h08);
    overheatRaw = 1'b1;
    wait_cycles(5);
    check_pin(2'(overheatShutdown), 2'h1);
    overheatRaw = 1'b0;
    wait_cycles(5);
    check_pin(2'(overheatShutdown), 2'h0);
    parallelBridgeMode = 1'b1;
    HOST.write_reg(8'h21, 8'h40);
    wait_cycles(2);
    check_pin(2'(parallelBridgeSourceFlip), 2'h1);
    HOST.write_reg(8'h21, 8'h00);
    wait_cycles(2);
    check_pin(2'(parallelBridgeSourceFlip), 2'h0);
  endtask : overheat_and_bridge

  // a write while the clock enable is low must be lost
  task automatic ce_freeze();
    ce = 1'b0;
    HOST.write_reg(8'h23, 8'h55);
    ce = 1'b1;
    check_reg(8'h23, 8'h03);
  endtask : ce_freeze

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // ceiling well above the few hundred cycles the run needs
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 8000) begin
      errors++;
      end_sim();
    end
  end

  initial begin
    rst_b = 1'b0;
    ce = 1'b1;
    diagResult = '0;
    diagResultValid = 1'b0;
    pwmCycleTick = 1'b0;
    pwmFullDuty = 2'h0;
    currentLimitRaw = 2'h0;
    overheatRaw = 1'b0;
    parallelBridgeMode = 1'b0;
    repeat (4) @(negedge clk_sys);
    rst_b = 1'b1;
    wait_cycles(3);
    reset_values();
    read_only_bytes();
    diag_reports();
    clip_latched();
    clip_follow();
    cap_flags();
    overheat_and_bridge();
    ce_freeze();
    end_sim();
  end
endmodule : tb
`default_nettype wire
